// ### logic/sws_pkg.sv
package sws_pkg;
	// ---------------------------------------------------------------
	// register map (byte addresses, one 32-bit word each)
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_SEG_A = 8'h08;
	localparam logic [7:0] REG_SEG_B = 8'h0c;
	localparam logic [7:0] REG_SEG_C = 8'h10;
	localparam logic [7:0] REG_HDR_NAME = 8'h14;
	localparam logic [7:0] REG_HDR_B = 8'h18;
	localparam logic [7:0] REG_HDR_PROT = 8'h1c;
	localparam logic [7:0] REG_ACTIVE = 8'h20;
	localparam logic [7:0] REG_ACTIVE_PROT = 8'h24;
	localparam logic [7:0] REG_SLOT_NAME = 8'h28;
	// ---------------------------------------------------------------
	// command codes, written to REG_CMD bits [2:0]
	// ---------------------------------------------------------------
	localparam logic [2:0] CMD_ADD_SEG = 3'h1;
	localparam logic [2:0] CMD_ERASE = 3'h2;
	localparam logic [2:0] CMD_RUN = 3'h3;
	localparam logic [2:0] CMD_STOP = 3'h4;
	localparam logic [2:0] CMD_SAVE_SETUP = 3'h5;
	localparam logic [2:0] CMD_RECALL = 3'h6;
	localparam logic [2:0] CMD_WRITE_HDR = 3'h7;
	// ---------------------------------------------------------------
	// sizes, limits and timing
	// ---------------------------------------------------------------
	localparam int NUM_WAVES = 16;
	localparam int MAX_SEGS = 10;
	localparam int POINT_BUDGET = 3933;
	localparam int LEVEL_POINTS = 60;
	localparam int FULL_CYCLE_DEG = 360;
	localparam int FRAC_ONE = 4096;
	localparam int SINE_TRI_MAX_CHZ = 44300;
	localparam int RAMP_MAX_CHZ = 53200;
	localparam int SQUARE_MAX_CHZ = 100000;
	localparam longint CLK_HZ = 250000000;
	localparam int MSG_TIME_MS = 1000;
	localparam int NUM_BANDS_ST = 20;
	localparam int NUM_BANDS_SQ = 22;
	// band upper edges in hundredths of a hertz, and points per cycle
	localparam int ST_EDGE [NUM_BANDS_ST] = '{270, 360, 550, 830, 1100, 1470, 2210, 3320, 4430, 5540,
		6650, 8870, 11830, 14790, 17740, 22180, 29580, 35490, 44370, 53200};
	localparam int ST_PTS [NUM_BANDS_ST] = '{3840, 2880, 1920, 1280, 960, 720, 480, 320, 240, 192,
		160, 120, 90, 72, 60, 48, 36, 30, 24, 20};
	localparam int SQ_EDGE [NUM_BANDS_SQ] = '{180, 270, 400, 540, 720, 1080, 1630, 2170, 2710, 3260,
		4350, 5800, 7250, 8700, 10870, 14500, 17400, 21750, 26100, 43500, 65250, 100000};
	localparam int SQ_PTS [NUM_BANDS_SQ] = '{3840, 2880, 1920, 1280, 960, 720, 480, 320, 240, 192,
		160, 120, 90, 72, 60, 48, 36, 30, 24, 20, 12, 10};
	// segment shapes, in register encoding order
	typedef enum logic [2:0] {
		SWS_SQUARE, SWS_POS_RAMP, SWS_NEG_RAMP, SWS_TRIANGLE, SWS_SINE, SWS_LEVEL
	} sws_seg_type_t;
	typedef enum logic [1:0] {
		SWS_PB_IDLE, SWS_PB_LOAD, SWS_PB_PLAY
	} sws_pb_state_t;
endpackage

// ### logic/sws_sequencer.sv
// Behaviour
// - Sixteen waveform slots, each viewable, runnable, modifiable or erasable.
// - Slot header: name, mode, protection pair, pass count; count zero repeats forever.
// - A waveform holds one to ten segments.
// - Each segment keeps type, frequency or period, amplitude, offset, angles, repeat flag.
// - Waveforms are played as a sequence of discrete output levels.
// - Points of all segments of a waveform stay within 3933; an overflowing segment is still stored, so the total can pass it.
// - A level segment uses at most 60 points.
// - Sine, triangle, ramp points per cycle come from their frequency band table.
// - Square points per cycle come from a separate band table, 3840 down to 10.
// - Point count fixed per band; point duration scales with the segment period.
// - Sine and triangle segments above 443 Hz are refused.
// - Ramp segments above 532 Hz are refused.
// - Each add rechecks the total; overflow flags the segment and shows a brief message.
// - Once the budget is used up, further segments are rejected.
// - Start and stop angles cut points in proportion to the kept part.
// - Erased slots read as empty, occupied slots read their name.
// - Before execution starts the static settings keep driving the output.
// - Recall copies a saved setup location into the active output settings.
// - Initial segments play on the first pass only; repeating ones every pass.
// - The last segment always repeats.
// - Stop halts execution and puts the output into standby.
//
// Added by the designer: the register addresses and the APB slave port.
module sws_sequencer import sws_pkg::*; #(
	parameter int NUM_SETUPS = 20,
	parameter int MSG_CYCLES = MSG_TIME_MS * int'(CLK_HZ / 1000)
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] out_level,
	output logic out_enable,
	output logic out_mode,
	output logic [15:0] out_prot_pos,
	output logic [15:0] out_prot_neg,
	output logic executing,
	output logic overflow_message
);
	localparam int SEG_DEPTH = NUM_WAVES * MAX_SEGS;

	// ---------------------------------------------------------------
	// point bookkeeping
	// ---------------------------------------------------------------
	// points per full cycle for a shape at a frequency (hundredths of Hz)
	function automatic int band_points(input logic [2:0] typ, input int chz);
		int res;
		res = 0;
		if (typ == 3'(SWS_LEVEL)) begin
			res = LEVEL_POINTS;
		end else if (typ == 3'(SWS_SQUARE)) begin
			for (int i = NUM_BANDS_SQ - 1; i >= 0; i--) begin
				if (chz <= SQ_EDGE[i]) res = SQ_PTS[i];
			end
		end else begin
			for (int i = NUM_BANDS_ST - 1; i >= 0; i--) begin
				if (chz <= ST_EDGE[i]) res = ST_PTS[i];
			end
		end
		return res;
	endfunction

	// first point index of the kept part of a cycle
	function automatic int first_index(input int base, input int sdeg, input int edeg, input logic [2:0] typ);
		int res;
		res = 0;
		if (typ != 3'(SWS_LEVEL) && edeg > sdeg && edeg <= FULL_CYCLE_DEG) res = base * sdeg / FULL_CYCLE_DEG;
		return res;
	endfunction

	// one-past-last point index of the kept part of a cycle
	function automatic int last_index(input int base, input int sdeg, input int edeg, input logic [2:0] typ);
		int res;
		res = base;
		if (typ != 3'(SWS_LEVEL) && edeg > sdeg && edeg <= FULL_CYCLE_DEG) res = base * edeg / FULL_CYCLE_DEG;
		return res;
	endfunction

	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	// header per slot, segments flattened as slot * MAX_SEGS + index
	logic wave_valid [NUM_WAVES];
	logic [31:0] wave_name [NUM_WAVES];
	logic wave_mode [NUM_WAVES];
	logic [15:0] wave_count [NUM_WAVES];
	logic [15:0] wave_pos [NUM_WAVES];
	logic [15:0] wave_neg [NUM_WAVES];
	logic [3:0] wave_nseg [NUM_WAVES];
	logic [12:0] wave_total [NUM_WAVES];
	logic [2:0] seg_type [SEG_DEPTH];
	logic seg_rep [SEG_DEPTH];
	logic [20:0] seg_freq [SEG_DEPTH];
	logic [15:0] seg_amp [SEG_DEPTH];
	logic [15:0] seg_off [SEG_DEPTH];
	logic [8:0] seg_start [SEG_DEPTH];
	logic [8:0] seg_stop [SEG_DEPTH];
	logic seg_flag [SEG_DEPTH];
	logic [15:0] setup_setting [NUM_SETUPS];
	logic [15:0] setup_pos [NUM_SETUPS];
	logic [15:0] setup_neg [NUM_SETUPS];
	logic setup_mode [NUM_SETUPS];
	logic setup_on [NUM_SETUPS];

	// staging and active settings
	logic [31:0] stage_seg_a, stage_seg_b, stage_seg_c, stage_name, stage_hdr_b, stage_prot;
	logic [15:0] act_setting, act_pos, act_neg;
	logic act_mode, act_on;
	logic [3:0] sel_slot;
	logic last_refused, last_flagged;
	logic [31:0] msg_timer;

	// ---------------------------------------------------------------
	// APB slave, zero wait states
	// ---------------------------------------------------------------
	logic wr_en, rd_en, cmd_go;
	logic [2:0] cmd_op;
	logic [3:0] cmd_slot;
	logic [4:0] cmd_loc;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign cmd_go = wr_en && paddr == REG_CMD;
	assign cmd_op = pwdata[2:0];
	assign cmd_slot = pwdata[11:8];
	assign cmd_loc = pwdata[20:16];

	sws_pb_state_t pb_state;
	logic [3:0] pb_slot, pb_seg;
	logic [15:0] pb_left;
	logic pb_first;

	// read mux; an unmapped address answers zero with an error
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel && !penable) begin
				case (paddr)
					REG_CMD: prdata <= {28'h0, sel_slot};
					REG_STATUS: prdata <= {3'h0, wave_total[sel_slot], 4'h0, wave_nseg[sel_slot],
						3'h0, wave_valid[sel_slot], last_flagged, last_refused, overflow_message, executing};
					REG_SEG_A: prdata <= stage_seg_a;
					REG_SEG_B: prdata <= stage_seg_b;
					REG_SEG_C: prdata <= stage_seg_c;
					REG_HDR_NAME: prdata <= stage_name;
					REG_HDR_B: prdata <= stage_hdr_b;
					REG_HDR_PROT: prdata <= stage_prot;
					REG_ACTIVE: prdata <= {14'h0, act_on, act_mode, act_setting};
					REG_ACTIVE_PROT: prdata <= {act_neg, act_pos};
					REG_SLOT_NAME: prdata <= wave_valid[sel_slot] ? wave_name[sel_slot] : 32'h0;
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// staging registers written by software
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			stage_seg_a <= 32'h0;
			stage_seg_b <= 32'h0;
			stage_seg_c <= 32'h0;
			stage_name <= 32'h0;
			stage_hdr_b <= 32'h0;
			stage_prot <= 32'h0;
		end else if (wr_en) begin
			case (paddr)
				REG_SEG_A: stage_seg_a <= pwdata;
				REG_SEG_B: stage_seg_b <= pwdata;
				REG_SEG_C: stage_seg_c <= pwdata;
				REG_HDR_NAME: stage_name <= pwdata;
				REG_HDR_B: stage_hdr_b <= pwdata;
				REG_HDR_PROT: stage_prot <= pwdata;
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// segment addition check
	// ---------------------------------------------------------------
	logic [2:0] add_type;
	int add_chz, add_base, add_pts, add_total;
	logic add_freq_bad, add_reject;
	always_comb begin
		add_type = stage_seg_a[2:0];
		add_chz = int'(stage_seg_a[28:8]);
		add_base = band_points(add_type, add_chz);
		// kept part of the cycle only costs its share of points
		add_pts = last_index(add_base, int'(stage_seg_c[8:0]), int'(stage_seg_c[24:16]), add_type)
			- first_index(add_base, int'(stage_seg_c[8:0]), int'(stage_seg_c[24:16]), add_type);
		add_total = int'(wave_total[cmd_slot]) + add_pts;
		add_freq_bad = ((add_type == 3'(SWS_SINE) || add_type == 3'(SWS_TRIANGLE)) && add_chz > SINE_TRI_MAX_CHZ)
			|| ((add_type == 3'(SWS_POS_RAMP) || add_type == 3'(SWS_NEG_RAMP)) && add_chz > RAMP_MAX_CHZ)
			|| (add_type == 3'(SWS_SQUARE) && add_chz > SQUARE_MAX_CHZ) || add_type > 3'(SWS_LEVEL) || add_chz == 0;
		add_reject = add_freq_bad || !wave_valid[cmd_slot] || wave_nseg[cmd_slot] >= 4'(MAX_SEGS)
			|| int'(wave_total[cmd_slot]) >= POINT_BUDGET;
	end

	// waveform store: header, segment add, setup save
	always_ff @(posedge ref_clk) begin
		if (cmd_go && cmd_op == CMD_WRITE_HDR && !(executing && pb_slot == cmd_slot)) begin
			wave_name[cmd_slot] <= stage_name;
			wave_mode[cmd_slot] <= stage_hdr_b[0];
			wave_count[cmd_slot] <= stage_hdr_b[31:16];
			wave_pos[cmd_slot] <= stage_prot[15:0];
			wave_neg[cmd_slot] <= stage_prot[31:16];
		end
		if (cmd_go && cmd_op == CMD_ADD_SEG && !add_reject) begin
			seg_type[cmd_slot * MAX_SEGS + wave_nseg[cmd_slot]] <= add_type;
			seg_rep[cmd_slot * MAX_SEGS + wave_nseg[cmd_slot]] <= stage_seg_a[4];
			seg_freq[cmd_slot * MAX_SEGS + wave_nseg[cmd_slot]] <= stage_seg_a[28:8];
			seg_amp[cmd_slot * MAX_SEGS + wave_nseg[cmd_slot]] <= stage_seg_b[15:0];
			seg_off[cmd_slot * MAX_SEGS + wave_nseg[cmd_slot]] <= stage_seg_b[31:16];
			seg_start[cmd_slot * MAX_SEGS + wave_nseg[cmd_slot]] <= stage_seg_c[8:0];
			seg_stop[cmd_slot * MAX_SEGS + wave_nseg[cmd_slot]] <= stage_seg_c[24:16];
			seg_flag[cmd_slot * MAX_SEGS + wave_nseg[cmd_slot]] <= add_total > POINT_BUDGET;
		end
		if (cmd_go && cmd_op == CMD_SAVE_SETUP && int'(cmd_loc) < NUM_SETUPS) begin
			setup_setting[cmd_loc] <= act_setting;
			setup_pos[cmd_loc] <= act_pos;
			setup_neg[cmd_loc] <= act_neg;
			setup_mode[cmd_loc] <= act_mode;
			setup_on[cmd_loc] <= act_on;
		end
	end

	// slot occupancy and point totals need reset values
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_WAVES; i++) begin
				wave_valid[i] <= 1'b0;
				wave_nseg[i] <= 4'h0;
				wave_total[i] <= 13'h0;
			end
			sel_slot <= 4'h0;
			last_refused <= 1'b0;
			last_flagged <= 1'b0;
		end else if (cmd_go && !(executing && pb_slot == cmd_slot && cmd_op != CMD_STOP)) begin
			sel_slot <= cmd_slot;
			if (cmd_op == CMD_WRITE_HDR) begin
				wave_valid[cmd_slot] <= 1'b1;
				wave_nseg[cmd_slot] <= 4'h0;
				wave_total[cmd_slot] <= 13'h0;
			end else if (cmd_op == CMD_ERASE) begin
				wave_valid[cmd_slot] <= 1'b0;
				wave_nseg[cmd_slot] <= 4'h0;
				wave_total[cmd_slot] <= 13'h0;
			end else if (cmd_op == CMD_ADD_SEG) begin
				last_refused <= add_reject;
				last_flagged <= !add_reject && add_total > POINT_BUDGET;
				if (!add_reject) begin
					wave_nseg[cmd_slot] <= wave_nseg[cmd_slot] + 4'h1;
					wave_total[cmd_slot] <= 13'(add_total);
				end
			end
		end
	end

	// overflow message stays up for a while; a new overflow restarts it
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			msg_timer <= 32'h0;
			overflow_message <= 1'b0;
		end else begin
			if (cmd_go && cmd_op == CMD_ADD_SEG && !add_reject && add_total > POINT_BUDGET) begin
				msg_timer <= 32'(MSG_CYCLES);
			end else if (msg_timer != 32'h0) begin
				msg_timer <= msg_timer - 32'h1;
			end
			overflow_message <= msg_timer != 32'h0;
		end
	end

	// ---------------------------------------------------------------
	// active settings and recall
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			act_setting <= 16'h0;
			act_pos <= 16'h0;
			act_neg <= 16'h0;
			act_mode <= 1'b0;
			act_on <= 1'b0;
		end else if (cmd_go && cmd_op == CMD_STOP && executing) begin
			act_on <= 1'b0;
		end else if (cmd_go && cmd_op == CMD_RECALL && int'(cmd_loc) < NUM_SETUPS && !executing) begin
			act_setting <= setup_setting[cmd_loc];
			act_pos <= setup_pos[cmd_loc];
			act_neg <= setup_neg[cmd_loc];
			act_mode <= setup_mode[cmd_loc];
			act_on <= setup_on[cmd_loc];
		end else if (wr_en && paddr == REG_ACTIVE) begin
			act_setting <= pwdata[15:0];
			act_mode <= pwdata[16];
			act_on <= pwdata[17];
		end else if (wr_en && paddr == REG_ACTIVE_PROT) begin
			act_pos <= pwdata[15:0];
			act_neg <= pwdata[31:16];
		end
	end

	// ---------------------------------------------------------------
	// playback engine
	// ---------------------------------------------------------------
	int cur_idx, end_idx, cur_base;
	logic [31:0] pt_cycles, pt_timer;
	int idx_ld;
	logic [2:0] ld_type;
	logic last_seg, seg_plays;
	longint ld_div;
	assign idx_ld = int'(pb_slot) * MAX_SEGS + int'(pb_seg);
	assign ld_type = seg_type[idx_ld];
	assign last_seg = pb_seg == wave_nseg[pb_slot] - 4'h1;
	// initial-only segments are skipped after the first pass; the last always plays
	assign seg_plays = pb_first || seg_rep[idx_ld] || last_seg;
	// level: period in ms over 60 points; others: period over the band's points
	assign ld_div = (ld_type == 3'(SWS_LEVEL)) ? longint'(LEVEL_POINTS) * 1000
		: longint'(seg_freq[idx_ld]) * longint'(band_points(ld_type, int'(seg_freq[idx_ld]))) / 100;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pb_state <= SWS_PB_IDLE;
			pb_slot <= 4'h0;
			pb_seg <= 4'h0;
			pb_left <= 16'h0;
			pb_first <= 1'b0;
			cur_idx <= 0;
			end_idx <= 0;
			cur_base <= 1;
			pt_cycles <= 32'h1;
			pt_timer <= 32'h0;
		end else begin
			case (pb_state)
				SWS_PB_IDLE: begin
					if (cmd_go && cmd_op == CMD_RUN && act_on && wave_valid[cmd_slot] && wave_nseg[cmd_slot] != 4'h0) begin
						pb_slot <= cmd_slot;
						pb_seg <= 4'h0;
						pb_left <= wave_count[cmd_slot];
						pb_first <= 1'b1;
						pb_state <= SWS_PB_LOAD;
					end
				end
				SWS_PB_LOAD: begin
					if (cmd_go && cmd_op == CMD_STOP) begin
						pb_state <= SWS_PB_IDLE;
					end else if (seg_plays) begin
						cur_base <= (ld_type == 3'(SWS_LEVEL)) ? LEVEL_POINTS : band_points(ld_type, int'(seg_freq[idx_ld]));
						cur_idx <= first_index(band_points(ld_type, int'(seg_freq[idx_ld])), int'(seg_start[idx_ld]),
							int'(seg_stop[idx_ld]), ld_type);
						end_idx <= last_index((ld_type == 3'(SWS_LEVEL)) ? LEVEL_POINTS
							: band_points(ld_type, int'(seg_freq[idx_ld])), int'(seg_start[idx_ld]),
							int'(seg_stop[idx_ld]), ld_type);
						// point time follows the period so the band's count meets the frequency
						pt_cycles <= 32'((CLK_HZ / ((ld_div == 0) ? 64'd1 : ld_div))
							* ((ld_type == 3'(SWS_LEVEL)) ? longint'(seg_freq[idx_ld]) : 64'd1));
						pt_timer <= 32'h0;
						pb_state <= SWS_PB_PLAY;
					end else begin
						pb_seg <= pb_seg + 4'h1;
					end
				end
				SWS_PB_PLAY: begin
					if (cmd_go && cmd_op == CMD_STOP) begin
						pb_state <= SWS_PB_IDLE;
					end else if (pt_timer + 32'h1 < pt_cycles) begin
						pt_timer <= pt_timer + 32'h1;
					end else begin
						pt_timer <= 32'h0;
						if (cur_idx + 1 < end_idx) begin
							cur_idx <= cur_idx + 1;
						end else if (!last_seg) begin
							pb_seg <= pb_seg + 4'h1;
							pb_state <= SWS_PB_LOAD;
						end else if (pb_left == 16'h1) begin
							pb_state <= SWS_PB_IDLE;
						end else begin
							if (pb_left != 16'h0) pb_left <= pb_left - 16'h1;
							pb_first <= 1'b0;
							pb_seg <= 4'h0;
							pb_state <= SWS_PB_LOAD;
						end
					end
				end
				default: pb_state <= SWS_PB_IDLE;
			endcase
		end
	end

	// shape value: fraction of cycle in 1/4096 steps, result spans +-amp/2 about offset
	int frac, tri_v, shape;
	logic signed [31:0] amp_s;
	always_comb begin
		frac = cur_idx * FRAC_ONE / ((cur_base == 0) ? 1 : cur_base);
		amp_s = 32'(signed'({1'b0, seg_amp[idx_ld]}));
		tri_v = (frac < FRAC_ONE / 4) ? frac : (frac < 3 * FRAC_ONE / 4) ? FRAC_ONE / 2 - frac : frac - FRAC_ONE;
		case (seg_type[idx_ld])
			3'(SWS_SQUARE): shape = (frac < FRAC_ONE / 2) ? int'(amp_s) / 2 : -int'(amp_s) / 2;
			3'(SWS_POS_RAMP): shape = (frac - FRAC_ONE / 2) * int'(amp_s) / FRAC_ONE;
			3'(SWS_NEG_RAMP): shape = (FRAC_ONE / 2 - frac) * int'(amp_s) / FRAC_ONE;
			3'(SWS_TRIANGLE): shape = tri_v * int'(amp_s) / (FRAC_ONE / 2);
			// parabola halves stand in for a sine table
			3'(SWS_SINE): shape = ((frac < FRAC_ONE / 2) ? frac * (FRAC_ONE / 2 - frac)
				: -((frac - FRAC_ONE / 2) * (FRAC_ONE - frac))) / 64 * int'(amp_s) / (FRAC_ONE * FRAC_ONE / 512);
			default: shape = 0;
		endcase
	end

	// output stage: static settings until a waveform is actually running
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			out_level <= 16'h0;
			out_enable <= 1'b0;
			out_mode <= 1'b0;
			out_prot_pos <= 16'h0;
			out_prot_neg <= 16'h0;
			executing <= 1'b0;
		end else begin
			executing <= pb_state != SWS_PB_IDLE;
			out_enable <= act_on;
			if (pb_state == SWS_PB_PLAY) begin
				out_level <= 16'(shape + int'(signed'(seg_off[idx_ld])));
				out_mode <= wave_mode[pb_slot];
				out_prot_pos <= wave_pos[pb_slot];
				out_prot_neg <= wave_neg[pb_slot];
			end else if (pb_state == SWS_PB_IDLE) begin
				out_level <= act_setting;
				out_mode <= act_mode;
				out_prot_pos <= act_pos;
				out_prot_neg <= act_neg;
			end
		end
	end
endmodule // sws_sequencer

// ### tb/sws_chk_props.sv
module sws_chk import sws_pkg::*; #(
	parameter int MSG_CYCLES = 20
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic out_enable,
	input wire logic pslverr,
	input wire logic executing,
	input wire logic overflow_message
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// ----
	// helpers
	// ----
	logic add_wr;
	logic [31:0] msg_cnt;
	assign add_wr = psel && penable && pwrite && paddr == REG_CMD && pwdata[2:0] == CMD_ADD_SEG;
	// counts how long the message has stood; restarts only make it longer
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) msg_cnt <= 32'h0;
		else if (!overflow_message) msg_cnt <= 32'h0;
		else msg_cnt <= msg_cnt + 32'h1;
	end
	sequence s_setup; psel && !penable; endsequence
	sequence s_stop; psel && penable && pwrite && paddr == REG_CMD && pwdata[2:0] == CMD_STOP; endsequence
	chk_zero_wait: assert property (s_setup |=> pready) else $error("no ready");
	chk_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
	chk_bad_addr: assert property (s_setup ##0 paddr > REG_SLOT_NAME |=> pslverr && prdata == 32'h0)
		else $error("no slave error");
	chk_good_addr: assert property (s_setup ##0 paddr <= REG_SLOT_NAME ##0 paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("false slave error");
	chk_msg_cause: assert property ($rose(overflow_message) |-> $past(add_wr, 2)) else $error("msg cause");
	chk_msg_hold: assert property ($fell(overflow_message) |-> msg_cnt >= MSG_CYCLES - 1)
		else $error("msg short");
	chk_stop_halts: assert property (s_stop ##0 executing |-> ##[1:4] !executing && !out_enable) else $error("stop");
	chk_run_on: assert property ($rose(executing) |-> out_enable) else $error("run while off");
endmodule // sws_chk

bind sws_sequencer sws_chk #(.MSG_CYCLES(MSG_CYCLES)) chk_u (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.out_enable(out_enable), .pslverr(pslverr), .executing(executing), .overflow_message(overflow_message));

// ### tb/sws_load_model.sv
module sws_load_model (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [15:0] out_level,
	input wire logic out_enable,
	output int level_steps
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] last_level;
	// output stage: counts level steps it is handed while powered
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			level_steps <= 0;
			last_level <= 16'h0;
		end else begin
			last_level <= out_level;
			if (out_enable && out_level !== last_level) level_steps <= level_steps + 1;
		end
	end
endmodule // sws_load_model

// ### tb/test_segmented_waveform_sequencer.sv
module test_segmented_waveform_sequencer import sws_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, out_enable, out_mode, executing, ovf, rerr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] out_level, pp, pn;
	logic [2:0] ty;
	int err_count, total_checks, steps, tot, f;
	sws_sequencer #(.MSG_CYCLES(20)) dut_u (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.out_level(out_level), .out_enable(out_enable), .out_mode(out_mode), .out_prot_pos(pp),
		.out_prot_neg(pn), .executing(executing), .overflow_message(ovf));
	sws_load_model load_u (.ref_clk(ref_clk), .nrst(nrst), .out_level(out_level), .out_enable(out_enable),
		.level_steps(steps));
	// ----
	// clock, bus and checks
	// ----
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task print_verdict;
		if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// one transfer; waits on pready, only the watchdog ends a hung slave
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task mk(input logic [3:0] s, input logic [15:0] cnt);
		apb(1'b1, REG_HDR_NAME, {28'h5741000, s});
		apb(1'b1, REG_HDR_B, {cnt, 16'h0});
		apb(1'b1, REG_HDR_PROT, 32'h6fff7ff0);
		apb(1'b1, REG_CMD, {20'h0, s, 5'h0, CMD_WRITE_HDR});
	endtask
	task seg(input logic [3:0] s, input logic [2:0] t, input int fr, input int sp, input int et, input logic rf);
		apb(1'b1, REG_SEG_A, {3'h0, fr[20:0], 5'h1, t});
		apb(1'b1, REG_SEG_B, 32'h00000400);
		apb(1'b1, REG_SEG_C, {7'h0, sp[8:0], 16'h0});
		apb(1'b1, REG_CMD, {20'h0, s, 5'h0, CMD_ADD_SEG});
		apb(1'b0, REG_STATUS, 32'h0);
		chk(et, {19'h0, rd[28:16]});
		chk(rf, rd[2]);
	endtask
	// expected points: band table, then the angle cut
	function int pts(logic [2:0] t, int fr, int sp);
		int b;
		b = 0;
		if (t == 3'h5) return LEVEL_POINTS;
		for (int i = 0; i < NUM_BANDS_SQ; i++) begin
			if (b == 0 && t == 3'h0 && fr <= SQ_EDGE[i]) b = SQ_PTS[i];
			if (b == 0 && t != 3'h0 && i < NUM_BANDS_ST && fr <= ST_EDGE[i]) b = ST_PTS[i];
		end
		if (sp > 0 && sp <= 360) b = b * sp / 360;
		return b;
	endfunction
	initial begin
		repeat (120000) @(posedge ref_clk);
		err_count++;
		print_verdict;
	end
	// ----
	// scenarios
	// ----
	initial begin
		{psel, penable, pwrite, paddr, pwdata, nrst, err_count, total_checks} = '0;
		void'($urandom(32'h6bebc61c));
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		apb(1'b0, 8'h2c, 32'h0);
		chk(1, rerr);
		mk(0, 16'h1);
		apb(1'b0, REG_SLOT_NAME, 32'h0);
		chk(32'h57410000, rd);
		seg(0, 3'h4, 10, 180, pts(3'h4, 10, 180), 0);
		seg(0, 3'h4, 44301, 0, 1920, 1);
		seg(0, 3'h1, 53201, 0, 1920, 1);
		seg(0, 3'h1, 53200, 0, 1940, 0);
		seg(0, 3'h5, 100, 0, 2000, 0);
		mk(1, 16'h1);
		tot = 0;
		for (int k = 0; k < 5; k++) begin
			tot += 960;
			seg(1, 3'h4, 1000, 0, tot, 0);
		end
		chk(1, rd[3]);
		chk(1, ovf);
		seg(1, 3'h4, 1000, 0, 4800, 1);
		for (int k = 3; k < 9; k++) begin
			ty = 3'($urandom_range(4, 0));
			f = $urandom_range(ty == 3'h0 ? 100000 : (ty > 3'h2 ? 44300 : 53200), 2);
			mk(4'(k), 16'h1);
			seg(4'(k), ty, f, 0, pts(ty, f, 0), 0);
		end
		mk(9, 16'h1);
		seg(9, 3'h0, 100000, 0, 10, 0);
		apb(1'b1, REG_CMD, {24'h1, 5'h0, CMD_ERASE});
		apb(1'b0, REG_SLOT_NAME, 32'h0);
		chk(0, rd);
		apb(1'b1, REG_ACTIVE, 32'h00001234);
		apb(1'b1, REG_CMD, {11'h0, 5'h3, 13'h0, CMD_SAVE_SETUP});
		apb(1'b1, REG_ACTIVE, 32'h0);
		apb(1'b1, REG_CMD, {11'h0, 5'h3, 13'h0, CMD_RECALL});
		apb(1'b0, REG_ACTIVE, 32'h0);
		chk(32'h1234, rd);
		mk(2, 16'h0);
		// cut to two points so a pass ends well inside the run window
		seg(2, 3'h4, 44300, 30, 2, 0);
		apb(1'b1, REG_ACTIVE, 32'h00020000); // zero setting first, as advised
		apb(1'b1, REG_ACTIVE_PROT, 32'h7fff7fff);
		repeat (2) @(posedge ref_clk);
		chk(1, out_enable);
		chk(0, executing);
		chk(32'h7fff7fff, {pn, pp});
		chk(0, {out_mode, out_level});
		apb(1'b1, REG_CMD, {24'h2, 5'h0, CMD_RUN});
		repeat (75000) @(posedge ref_clk);
		chk(1, executing);
		chk(32'h6fff7ff0, {pn, pp});
		chk(1, steps > 1);
		apb(1'b1, REG_CMD, {24'h2, 5'h0, CMD_STOP});
		repeat (4) @(posedge ref_clk);
		chk(0, {executing, out_enable});
		print_verdict;
	end
endmodule // test_segmented_waveform_sequencer
